// ---- hdl/i2cs_pkg.sv ----
package i2cs_pkg;
   // Fixed seven-bit bus address of the register slave.
   localparam logic [6:0] DEV_BUS_ADDR = 7'h5f;
   // Reference clock period and fastest serial clock period, in ns.
   localparam int CLK_PERIOD_NS = 40;
   localparam int SCL_PERIOD_NS = 2500;
   // Cycles per quarter of a serial bit, rounded up so the bus never runs fast.
   localparam int QTR_CYC = (SCL_PERIOD_NS + 4 * CLK_PERIOD_NS - 1) / (4 * CLK_PERIOD_NS);
   // Depth of the write buffer in the slave.
   localparam int FIFO_DEPTH = 8;
   // Index of the last bit of a byte and of the acknowledge bit.
   localparam logic [2:0] LAST_BIT = 3'h7;
   localparam logic [3:0] ACK_BIT = 4'h8;
   // Slave states and the kind of byte being received.
   typedef enum logic [2:0] {SS_IDLE, SS_RX, SS_HOLD, SS_ACK, SS_TX, SS_MACK, SS_IGNORE} i2cs_sstate_t;
   typedef enum logic [1:0] {RK_ADDR, RK_REG, RK_DATA} i2cs_kind_t;
   // Master bit-engine states and transfer steps.
   typedef enum logic [1:0] {MP_IDLE, MP_START, MP_BIT, MP_STOP} i2cs_mstate_t;
   typedef enum logic [2:0] {MS_ADDRW, MS_REG, MS_WDATA, MS_ADDRR, MS_RDATA} i2cs_step_t;
endpackage : i2cs_pkg

// ---- hdl/i2cs_bus_if.sv ----
`timescale 1ns/1ns
`default_nettype none
interface i2cs_bus_if;
   logic m_scl_o;
   logic m_scl_oe_n;
   logic m_sda_o;
   logic m_sda_oe_n;
   logic s_scl_o;
   logic s_scl_oe_n;
   logic s_sda_o;
   logic s_sda_oe_n;
   logic scl;
   logic sda;
   // Open-drain lines with pull-ups: a line is low when any enabled driver pulls it low.
   assign scl = (m_scl_oe_n | m_scl_o) & (s_scl_oe_n | s_scl_o);
   assign sda = (m_sda_oe_n | m_sda_o) & (s_sda_oe_n | s_sda_o);
   modport host (input scl, input sda, output m_scl_o, output m_scl_oe_n, output m_sda_o, output m_sda_oe_n);
   modport dev (input scl, input sda, output s_scl_o, output s_scl_oe_n, output s_sda_o, output s_sda_oe_n);
endinterface : i2cs_bus_if
`default_nettype wire

// ---- hdl/i2cs_slave.sv ----
// Contract
// - Interface select high enables, low disables.
// - Acts only as slave, register write/read.
// - Works at standard and 400 kHz rates.
// - SDA fall with SCL high starts transaction.
// - First seven bits address, eighth bit direction.
// - Own address fixed at 1011111.
// - Transmitter releases, receiver holds ack low.
// - Addressed slave acknowledges every received byte.
// - Register byte: low seven address, top increment.
// - Increment set advances address after each byte; reads advance on master acknowledge only.
// - Read uses write phase, repeated start, read.
// - Write sends address, register, data, stop.
// - Single read ends with no-acknowledge, stop.
// - Burst read continues while master acknowledges.
// - SDA rise with SCL high stops, idles.
// - Bytes are eight bits, MSB first.
`timescale 1ns/1ns
`default_nettype none
module i2cs_fifo #(
   parameter int W = 15,
   parameter int D = 8
) (
   input wire logic i_ref_clk,
   input wire logic i_sys_rst,
   input wire logic i_clk_en,
   input wire logic i_in_valid,
   output logic o_in_ready,
   input wire logic [W-1:0] i_in_data,
   output logic o_out_valid,
   input wire logic i_out_ready,
   output logic [W-1:0] o_out_data
);
   localparam int AW = $clog2(D);
   logic [W-1:0] mem_q [D];
   logic [AW-1:0] wp_q;
   logic [AW-1:0] rp_q;
   logic [AW:0] cnt_q;
   wire push = i_in_valid & o_in_ready;
   wire pop = o_out_valid & i_out_ready;

   // Full and empty come straight from the fill count.
   assign o_in_ready = (cnt_q != (AW + 1)'(D));
   assign o_out_valid = (cnt_q != '0);
   assign o_out_data = mem_q[rp_q];

   // Storage array, written only on an accepted push.
   always_ff @(posedge i_ref_clk) begin
      if (i_clk_en && push) begin
         mem_q[wp_q] <= i_in_data;
      end
   end

   // Pointers wrap at the depth; the count tracks pushes less pops.
   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         wp_q <= '0;
         rp_q <= '0;
         cnt_q <= '0;
      end else if (i_clk_en) begin
         if (push) begin
            wp_q <= (wp_q == AW'(D - 1)) ? '0 : wp_q + 1'b1;
         end
         if (pop) begin
            rp_q <= (rp_q == AW'(D - 1)) ? '0 : rp_q + 1'b1;
         end
         cnt_q <= cnt_q + (AW + 1)'(push) - (AW + 1)'(pop);
      end
   end
endmodule : i2cs_fifo

module i2cs_slave import i2cs_pkg::*; #(
   parameter logic [6:0] BUS_ADDR = DEV_BUS_ADDR,
   parameter int DEPTH = FIFO_DEPTH
) (
   input wire logic i_ref_clk,
   input wire logic i_sys_rst,
   input wire logic i_clk_en,
   input wire logic i_if_sel,
   i2cs_bus_if.dev bus,
   output logic o_wr_valid,
   input wire logic i_wr_ready,
   output logic [6:0] o_wr_addr,
   output logic [7:0] o_wr_data,
   output logic [6:0] o_rd_addr,
   input wire logic [7:0] i_rd_data,
   output logic o_busy
);
   i2cs_sstate_t state_q;
   i2cs_kind_t kind_q;
   logic scl_q;
   logic sda_q;
   logic [2:0] cnt_q;
   logic full_q;
   logic [7:0] sh_q;
   logic [6:0] reg_q;
   logic inc_q;
   logic rd_q;
   logic ack_q;
   logic sda_oe_n_q;
   logic scl_oe_n_q;
   logic fifo_ready;
   logic [14:0] fifo_out;

   // Line edges and bus conditions from the previous sample.
   wire scl_rise = bus.scl & ~scl_q;
   wire scl_fall = ~bus.scl & scl_q;
   wire start_det = bus.scl & scl_q & sda_q & ~bus.sda;
   wire stop_det = bus.scl & scl_q & ~sda_q & bus.sda;
   wire addr_hit = (sh_q[7:1] == BUS_ADDR);
   wire push = (state_q == SS_HOLD);

   // Open-drain drivers only ever pull low; the enables carry the data.
   assign bus.s_sda_o = 1'b0;
   assign bus.s_scl_o = 1'b0;
   assign bus.s_sda_oe_n = sda_oe_n_q;
   assign bus.s_scl_oe_n = scl_oe_n_q;
   assign o_rd_addr = reg_q;
   assign o_busy = (state_q != SS_IDLE);
   assign o_wr_addr = fifo_out[14:8];
   assign o_wr_data = fifo_out[7:0];

   // Written bytes wait here with their register address; a full buffer stretches the clock.
   i2cs_fifo #(.W(15), .D(DEPTH)) u_wbuf (
      .i_ref_clk(i_ref_clk),
      .i_sys_rst(i_sys_rst),
      .i_clk_en(i_clk_en),
      .i_in_valid(push),
      .o_in_ready(fifo_ready),
      .i_in_data({reg_q, sh_q}),
      .o_out_valid(o_wr_valid),
      .i_out_ready(i_wr_ready),
      .o_out_data(fifo_out)
   );

   // Protocol engine: samples on rising clock edges and changes the data line on falling ones.
   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         state_q <= SS_IDLE;
         kind_q <= RK_ADDR;
         scl_q <= 1'b1;
         sda_q <= 1'b1;
         cnt_q <= '0;
         full_q <= 1'b0;
         sh_q <= '0;
         reg_q <= '0;
         inc_q <= 1'b0;
         rd_q <= 1'b0;
         ack_q <= 1'b0;
         sda_oe_n_q <= 1'b1;
         scl_oe_n_q <= 1'b1;
      end else if (i_clk_en) begin
         scl_q <= bus.scl;
         sda_q <= bus.sda;
         if (!i_if_sel) begin
            state_q <= SS_IDLE;
            sda_oe_n_q <= 1'b1;
            scl_oe_n_q <= 1'b1;
         end else if (start_det) begin
            state_q <= SS_RX;
            kind_q <= RK_ADDR;
            cnt_q <= '0;
            full_q <= 1'b0;
            sda_oe_n_q <= 1'b1;
            scl_oe_n_q <= 1'b1;
         end else if (stop_det) begin
            state_q <= SS_IDLE;
            sda_oe_n_q <= 1'b1;
            scl_oe_n_q <= 1'b1;
         end else begin
            case (state_q)
               SS_RX: begin
                  if (scl_rise) begin
                     sh_q <= {sh_q[6:0], bus.sda};
                     cnt_q <= cnt_q + 3'h1;
                     full_q <= (cnt_q == LAST_BIT);
                  end else if (scl_fall && full_q) begin
                     full_q <= 1'b0;
                     if (kind_q == RK_ADDR) begin
                        if (addr_hit) begin
                           rd_q <= sh_q[0];
                           state_q <= SS_ACK;
                           sda_oe_n_q <= 1'b0;
                        end else begin
                           state_q <= SS_IGNORE;
                        end
                     end else if (kind_q == RK_REG) begin
                        reg_q <= sh_q[6:0];
                        inc_q <= sh_q[7];
                        state_q <= SS_ACK;
                        sda_oe_n_q <= 1'b0;
                     end else begin
                        state_q <= SS_HOLD;
                        sda_oe_n_q <= 1'b0;
                        scl_oe_n_q <= 1'b0;
                     end
                  end
               end
               SS_HOLD: begin
                  if (fifo_ready) begin
                     state_q <= SS_ACK;
                     scl_oe_n_q <= 1'b1;
                     if (inc_q) begin
                        reg_q <= reg_q + 7'h1;
                     end
                  end
               end
               SS_ACK: begin
                  if (scl_fall) begin
                     cnt_q <= '0;
                     if (kind_q == RK_ADDR && rd_q) begin
                        sh_q <= i_rd_data;
                        sda_oe_n_q <= i_rd_data[7];
                        state_q <= SS_TX;
                     end else begin
                        sda_oe_n_q <= 1'b1;
                        state_q <= SS_RX;
                        kind_q <= (kind_q == RK_ADDR) ? RK_REG : RK_DATA;
                     end
                  end
               end
               SS_TX: begin
                  if (scl_rise) begin
                     cnt_q <= cnt_q + 3'h1;
                  end else if (scl_fall) begin
                     if (cnt_q == '0) begin
                        sda_oe_n_q <= 1'b1;
                        state_q <= SS_MACK;
                     end else begin
                        sh_q <= {sh_q[6:0], 1'b0};
                        sda_oe_n_q <= sh_q[6];
                     end
                  end
               end
               SS_MACK: begin
                  if (scl_rise) begin
                     ack_q <= ~bus.sda;
                     if (~bus.sda && inc_q) begin
                        reg_q <= reg_q + 7'h1;
                     end
                  end else if (scl_fall) begin
                     if (ack_q) begin
                        sh_q <= i_rd_data;
                        sda_oe_n_q <= i_rd_data[7];
                        state_q <= SS_TX;
                     end else begin
                        state_q <= SS_IGNORE;
                     end
                  end
               end
               default: begin
                  sda_oe_n_q <= 1'b1;
               end
            endcase
         end
      end
   end
endmodule : i2cs_slave
`default_nettype wire

// ---- hdl/i2cs_master.sv ----
`timescale 1ns/1ns
`default_nettype none
module i2cs_master import i2cs_pkg::*; #(
   parameter int QTR = QTR_CYC
) (
   input wire logic i_ref_clk,
   input wire logic i_sys_rst,
   input wire logic i_clk_en,
   i2cs_bus_if.host bus,
   input wire logic i_cmd_valid,
   output logic o_cmd_ready,
   input wire logic i_cmd_rd,
   input wire logic i_cmd_inc,
   input wire logic [6:0] i_cmd_reg,
   input wire logic [3:0] i_cmd_len,
   input wire logic [7:0] i_wr_data,
   output logic o_wr_take,
   output logic o_rd_valid,
   output logic [7:0] o_rd_data,
   output logic o_nack,
   output logic o_busy
);
   i2cs_mstate_t state_q;
   i2cs_step_t step_q;
   logic [7:0] qcnt_q;
   logic [1:0] ph_q;
   logic [3:0] bit_q;
   logic [3:0] len_q;
   logic [7:0] sh_q;
   logic [7:0] rx_q;
   logic [6:0] reg_q;
   logic rd_q;
   logic inc_q;
   logic nack_q;
   logic scl_rel_q;
   logic sda_rel_q;

   // A released clock held low by the slave stalls the quarter timer.
   wire stall = scl_rel_q & ~bus.scl;
   wire tick = (qcnt_q == 8'(QTR - 1)) & ~stall;
   wire tx = (step_q != MS_RDATA);
   wire last = (len_q == '0);

   assign bus.m_scl_o = 1'b0;
   assign bus.m_sda_o = 1'b0;
   assign bus.m_scl_oe_n = scl_rel_q;
   assign bus.m_sda_oe_n = sda_rel_q;
   assign o_cmd_ready = (state_q == MP_IDLE);
   assign o_busy = (state_q != MP_IDLE);

   // Quarter-bit timer and phase counter.
   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         qcnt_q <= '0;
         ph_q <= '0;
      end else if (i_clk_en) begin
         if (state_q == MP_IDLE) begin
            qcnt_q <= '0;
            ph_q <= '0;
         end else if (!stall) begin
            qcnt_q <= tick ? '0 : qcnt_q + 8'h1;
            ph_q <= tick ? ph_q + 2'h1 : ph_q;
         end
      end
   end

   // Transfer sequencer and line drivers; each phase ends on a tick.
   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         state_q <= MP_IDLE;
         step_q <= MS_ADDRW;
         bit_q <= '0;
         len_q <= '0;
         sh_q <= '0;
         rx_q <= '0;
         reg_q <= '0;
         rd_q <= 1'b0;
         inc_q <= 1'b0;
         nack_q <= 1'b0;
         scl_rel_q <= 1'b1;
         sda_rel_q <= 1'b1;
         o_wr_take <= 1'b0;
         o_rd_valid <= 1'b0;
         o_rd_data <= '0;
         o_nack <= 1'b0;
      end else if (i_clk_en) begin
         o_wr_take <= 1'b0;
         o_rd_valid <= 1'b0;
         o_nack <= 1'b0;
         case (state_q)
            MP_IDLE: begin
               if (i_cmd_valid) begin
                  rd_q <= i_cmd_rd;
                  inc_q <= i_cmd_inc;
                  reg_q <= i_cmd_reg;
                  len_q <= i_cmd_len;
                  step_q <= MS_ADDRW;
                  state_q <= MP_START;
               end
            end
            MP_START: begin
               if (tick) begin
                  if (ph_q == 2'h0) begin
                     sda_rel_q <= 1'b1;
                  end else if (ph_q == 2'h1) begin
                     scl_rel_q <= 1'b1;
                  end else if (ph_q == 2'h2) begin
                     sda_rel_q <= 1'b0;
                  end else begin
                     scl_rel_q <= 1'b0;
                     sh_q <= {DEV_BUS_ADDR, step_q == MS_ADDRR};
                     bit_q <= '0;
                     state_q <= MP_BIT;
                  end
               end
            end
            MP_BIT: begin
               if (tick) begin
                  if (ph_q == 2'h0) begin
                     if (bit_q == ACK_BIT) begin
                        sda_rel_q <= tx | last;
                     end else begin
                        sda_rel_q <= tx ? sh_q[7] : 1'b1;
                     end
                  end else if (ph_q == 2'h1) begin
                     scl_rel_q <= 1'b1;
                  end else if (ph_q == 2'h2) begin
                     if (bit_q == ACK_BIT) begin
                        nack_q <= bus.sda;
                     end else begin
                        rx_q <= {rx_q[6:0], bus.sda};
                     end
                  end else begin
                     scl_rel_q <= 1'b0;
                     sh_q <= {sh_q[6:0], 1'b0};
                     bit_q <= bit_q + 4'h1;
                     if (bit_q == ACK_BIT) begin
                        bit_q <= '0;
                        if (tx && nack_q) begin
                           o_nack <= 1'b1;
                           state_q <= MP_STOP;
                        end else begin
                           case (step_q)
                              MS_ADDRW: begin
                                 sh_q <= {inc_q, reg_q};
                                 step_q <= MS_REG;
                              end
                              MS_REG: begin
                                 if (rd_q) begin
                                    step_q <= MS_ADDRR;
                                    state_q <= MP_START;
                                 end else begin
                                    step_q <= MS_WDATA;
                                    sh_q <= i_wr_data;
                                    o_wr_take <= 1'b1;
                                 end
                              end
                              MS_WDATA: begin
                                 if (last) begin
                                    state_q <= MP_STOP;
                                 end else begin
                                    len_q <= len_q - 4'h1;
                                    sh_q <= i_wr_data;
                                    o_wr_take <= 1'b1;
                                 end
                              end
                              MS_ADDRR: begin
                                 step_q <= MS_RDATA;
                              end
                              default: begin
                                 o_rd_valid <= 1'b1;
                                 o_rd_data <= rx_q;
                                 if (last) begin
                                    state_q <= MP_STOP;
                                 end else begin
                                    len_q <= len_q - 4'h1;
                                 end
                              end
                           endcase
                        end
                     end
                  end
               end
            end
            default: begin
               if (tick) begin
                  if (ph_q == 2'h0) begin
                     sda_rel_q <= 1'b0;
                  end else if (ph_q == 2'h1) begin
                     scl_rel_q <= 1'b1;
                  end else if (ph_q == 2'h2) begin
                     sda_rel_q <= 1'b1;
                  end else begin
                     state_q <= MP_IDLE;
                  end
               end
            end
         endcase
      end
   end
endmodule : i2cs_master
`default_nettype wire

// ---- tb/i2cs_link_asserts.sv ----
`timescale 1ns/1ns
`default_nettype none
module i2cs_link_asserts (
   input wire logic i_ref_clk,
   input wire logic i_sys_rst,
   input wire logic m_scl_oe_n,
   input wire logic m_sda_oe_n,
   input wire logic s_scl_oe_n,
   input wire logic s_sda_oe_n,
   input wire logic scl,
   input wire logic sda
);
   logic scl_q;
   logic sda_q;
   logic first_q;
   logic rd_q;
   logic nak_q;
   logic [3:0] cnt_q;
   logic rise;
   logic start;
   logic stop;
   // Line events seen from the previous sample of both lines.
   assign rise = scl & ~scl_q;
   assign start = scl & scl_q & sda_q & ~sda;
   assign stop = scl & scl_q & ~sda_q & sda;
   // Counts clock rises within a byte; the ninth rise is the acknowledge slot.
   always_ff @(posedge i_ref_clk) begin
      if (i_sys_rst) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
         cnt_q <= 4'h0;
         first_q <= 1'b1;
         rd_q <= 1'b0;
         nak_q <= 1'b0;
      end else begin
         scl_q <= scl;
         sda_q <= sda;
         if (start || stop) begin
            cnt_q <= 4'h0;
            first_q <= 1'b1;
            nak_q <= 1'b0;
         end else if (rise) begin
            cnt_q <= (cnt_q == 4'h8) ? 4'h0 : cnt_q + 4'h1;
            first_q <= first_q & (cnt_q != 4'h8);
            // A high master acknowledge slot ends the read; the next rise belongs to the stop.
            nak_q <= nak_q | (!first_q && rd_q && cnt_q == 4'h8 && sda);
         end
         if (rise && first_q && cnt_q == 4'h7) begin
            rd_q <= sda; // The direction bit of the address byte.
         end
      end
   end

   default clocking cb @(posedge i_ref_clk);
   endclocking
   default disable iff (i_sys_rst);

   property p_addr_ack;
      rise && first_q && cnt_q == 4'h8 |-> !s_sda_oe_n && !sda;
   endproperty
   a_addr_ack: assert property (p_addr_ack) else $error("Address byte not acknowledged.");
   property p_byte_ack;
      rise && !first_q && !rd_q && cnt_q == 4'h8 |-> !s_sda_oe_n && !sda;
   endproperty
   a_byte_ack: assert property (p_byte_ack) else $error("Received byte not acknowledged.");
   property p_mack_free;
      rise && !first_q && rd_q && cnt_q == 4'h8 |-> s_sda_oe_n;
   endproperty
   a_mack_free: assert property (p_mack_free) else $error("Slave drives the master acknowledge slot.");
   property p_rd_bits;
      rise && !first_q && rd_q && !nak_q && cnt_q != 4'h8 |-> m_sda_oe_n && (sda == s_sda_oe_n);
   endproperty
   a_rd_bits: assert property (p_rd_bits) else $error("Read bit not driven by the slave.");
   property p_nak_quiet;
      rise && nak_q |-> s_sda_oe_n;
   endproperty
   a_nak_quiet: assert property (p_nak_quiet) else $error("Slave drives data after a no-acknowledge.");
   property p_addr_quiet;
      rise && first_q && cnt_q != 4'h8 |-> s_sda_oe_n;
   endproperty
   a_addr_quiet: assert property (p_addr_quiet) else $error("Slave drives data during the address.");
   property p_ack_hold;
      rise && !s_sda_oe_n |-> !s_sda_oe_n throughout (##[0:64] !scl);
   endproperty
   a_ack_hold: assert property (p_ack_hold) else $error("Slave low level not held through clock high.");
   property p_stop_idle;
      stop |-> ##1 (s_sda_oe_n && s_scl_oe_n);
   endproperty
   a_stop_idle: assert property (p_stop_idle) else $error("Slave not released after a stop.");
   property p_sda_edge;
      $changed(s_sda_oe_n) |-> !scl;
   endproperty
   a_sda_edge: assert property (p_sda_edge) else $error("Slave data changed while clock high.");
endmodule : i2cs_link_asserts
`default_nettype wire

// ---- tb/tb_i2c_register_access_slave.sv ----
`timescale 1ns/1ns
`default_nettype none
module tb_i2c_register_access_slave import i2cs_pkg::*;;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic en = 1'b1;
   logic cv = 1'b0;
   logic cv2 = 1'b0;
   logic crd = 1'b0;
   logic cinc = 1'b0;
   logic sel2 = 1'b0;
   logic wrdy = 1'b0;
   logic [6:0] creg = 7'h00;
   logic [3:0] clen = 4'h0;
   logic [7:0] wd0 = 8'h00;
   logic [7:0] wstep = 8'h00;
   logic [7:0] wdat;
   logic m_rdy, m_take, m_rv, m_nack, m_busy, s_wv, s_busy, m2_rdy, m2_nack, m2_busy, s2_wv;
   logic [7:0] m_rd, s_wd, rdat;
   logic [6:0] s_wa, s_ra, s2_wa;
   int fail_count = 0;
   int comparisons = 0;
   int nacks = 0;
   int nacks2 = 0;

   i2cs_bus_if bus1();
   i2cs_bus_if bus2();
   i2cs_master #(.QTR(4)) i2cs_master_i (.i_ref_clk(clk), .i_sys_rst(rst), .i_clk_en(en), .bus(bus1),
      .i_cmd_valid(cv), .o_cmd_ready(m_rdy), .i_cmd_rd(crd), .i_cmd_inc(cinc), .i_cmd_reg(creg),
      .i_cmd_len(clen), .i_wr_data(wdat), .o_wr_take(m_take), .o_rd_valid(m_rv), .o_rd_data(m_rd),
      .o_nack(m_nack), .o_busy(m_busy));
   i2cs_slave i2cs_slave_i (.i_ref_clk(clk), .i_sys_rst(rst), .i_clk_en(en), .i_if_sel(1'b1), .bus(bus1),
      .o_wr_valid(s_wv), .i_wr_ready(wrdy), .o_wr_addr(s_wa), .o_wr_data(s_wd), .o_rd_addr(s_ra),
      .i_rd_data(rdat), .o_busy(s_busy));
   i2cs_link_asserts i2cs_link_asserts_i (.i_ref_clk(clk), .i_sys_rst(rst), .m_scl_oe_n(bus1.m_scl_oe_n),
      .m_sda_oe_n(bus1.m_sda_oe_n), .s_scl_oe_n(bus1.s_scl_oe_n), .s_sda_oe_n(bus1.s_sda_oe_n),
      .scl(bus1.scl), .sda(bus1.sda));
   // The second pair exercises the interface select of the slave.
   i2cs_master #(.QTR(4)) i2cs_master_2_i (.i_ref_clk(clk), .i_sys_rst(rst), .i_clk_en(en), .bus(bus2),
      .i_cmd_valid(cv2), .o_cmd_ready(m2_rdy), .i_cmd_rd(crd), .i_cmd_inc(cinc), .i_cmd_reg(creg),
      .i_cmd_len(clen), .i_wr_data(wdat), .o_wr_take(), .o_rd_valid(), .o_rd_data(),
      .o_nack(m2_nack), .o_busy(m2_busy));
   i2cs_slave i2cs_slave_2_i (.i_ref_clk(clk), .i_sys_rst(rst), .i_clk_en(en), .i_if_sel(sel2), .bus(bus2),
      .o_wr_valid(s2_wv), .i_wr_ready(1'b0), .o_wr_addr(s2_wa), .o_wr_data(), .o_rd_addr(),
      .i_rd_data(8'h00), .o_busy());

   // Register content seen by the slave is a fixed function of the register address.
   function automatic logic [7:0] exp_rd(input logic [6:0] a);
      return {a, 1'b0} ^ 8'ha5;
   endfunction : exp_rd
   assign rdat = exp_rd(s_ra);

   always #20 clk = ~clk;

   // Counts refusals and supplies the next write byte once one is loaded.
   always @(negedge clk) begin
      nacks += int'(m_nack === 1'b1);
      nacks2 += int'(m2_nack === 1'b1);
   end
   always @(posedge clk) begin
      if (cv || cv2) begin
         wstep <= 8'h00;
      end else if (m_take === 1'b1) begin
         wstep <= wstep + 8'h13;
      end
   end
   assign wdat = wd0 + wstep;

   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic test_done;
      $display("Comparisons %0d, mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : test_done

   task automatic wait_idle(input logic second);
      int n;
      n = 0;
      do begin
         @(posedge clk);
         #1;
         n++;
      end while ((second ? m2_busy : m_busy) !== 1'b0 && n < 20000);
      repeat (4) @(posedge clk);
      #1;
      check("master idle", {15'h0, second ? m2_busy : m_busy}, 16'h0);
      if (!second) check("slave idle", {15'h0, s_busy}, 16'h0);
   endtask : wait_idle

   task automatic cmd(input logic second, rd, inc, input logic [6:0] rg, input logic [3:0] len,
                      input logic [7:0] d);
      wait_idle(second);
      @(posedge clk);
      crd <= rd;
      cinc <= inc;
      creg <= rg;
      clen <= len;
      wd0 <= d;
      cv <= ~second;
      cv2 <= second;
      @(posedge clk);
      cv <= 1'b0;
      cv2 <= 1'b0;
   endtask : cmd

   task automatic pop(input logic [6:0] a, input logic [7:0] d);
      int n;
      n = 0;
      do begin
         @(posedge clk);
         #1;
         n++;
      end while (s_wv !== 1'b1 && n < 20000);
      check("write address", {9'h0, s_wa}, {9'h0, a});
      check("write data", {8'h0, s_wd}, {8'h0, d});
      @(posedge clk);
      wrdy <= 1'b1;
      @(posedge clk);
      wrdy <= 1'b0;
   endtask : pop

   // Writes len+1 bytes; a burst longer than the buffer must stall until drained.
   task automatic t_write(input logic [6:0] rg, input logic inc, input logic [3:0] len, input logic [7:0] d);
      int k;
      cmd(1'b0, 1'b0, inc, rg, len, d);
      if (len > 4'h7) begin
         repeat (3000) @(posedge clk);
         #1;
         check("stalled master", {15'h0, m_busy}, 16'h1);
         check("full buffer", {15'h0, s_wv}, 16'h1);
      end
      for (k = 0; k <= int'(len); k++) begin
         pop(rg + (inc ? 7'(k) : 7'h00), d + 8'(k * 19));
      end
      wait_idle(1'b0);
      check("write refusals", 16'(nacks), 16'h0);
   endtask : t_write

   // Reads len+1 bytes and compares them with the register function.
   task automatic t_read(input logic [6:0] rg, input logic inc, input logic [3:0] len);
      int k;
      int n;
      cmd(1'b0, 1'b1, inc, rg, len, 8'h00);
      for (k = 0; k <= int'(len); k++) begin
         n = 0;
         do begin
            @(posedge clk);
            #1;
            n++;
         end while (m_rv !== 1'b1 && n < 20000);
         check("read data", {8'h0, m_rd}, {8'h0, exp_rd(rg + (inc ? 7'(k) : 7'h00))});
      end
      wait_idle(1'b0);
      check("read refusals", 16'(nacks), 16'h0);
   endtask : t_read

   // A deselected slave must not answer; once selected it takes the write.
   task automatic t_select;
      cmd(1'b1, 1'b0, 1'b0, 7'h33, 4'h0, 8'h55);
      wait_idle(1'b1);
      check("deselected refusal", 16'(nacks2), 16'h1);
      check("deselected buffer", {15'h0, s2_wv}, 16'h0);
      @(posedge clk);
      sel2 <= 1'b1;
      cmd(1'b1, 1'b0, 1'b0, 7'h33, 4'h0, 8'h55);
      wait_idle(1'b1);
      check("selected refusal", 16'(nacks2), 16'h1);
      check("selected buffer", {15'h0, s2_wv}, 16'h1);
      check("selected address", {9'h0, s2_wa}, 16'h0033);
   endtask : t_select

   initial begin
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      #1;
      check("idle lines", {14'h0, bus1.scl, bus1.sda}, 16'h3);
      check("command ready", {15'h0, m_rdy}, 16'h1);
      t_write(7'h15, 1'b0, 4'h0, 8'h3c);
      t_write(7'h20, 1'b0, 4'h1, 8'h70);
      t_write(7'h7d, 1'b1, 4'h9, 8'h40);
      t_read(7'h0a, 1'b0, 4'h0);
      t_read(7'h3e, 1'b1, 4'h2);
      t_read(7'h11, 1'b0, 4'h1);
      t_select;
      test_done;
   end

   // Cuts a hang short well after the expected run length.
   initial begin
      repeat (60000) @(posedge clk);
      fail_count++;
      $display("Watchdog expired");
      test_done;
   end
endmodule : tb_i2c_register_access_slave
`default_nettype wire
